// file: src/power_monitor_serial_slave.sv
// Purpose: Two-wire serial slave of a power monitor, register access side
// Assumes: Bus lines oversampled by clk_in; register file on clk_in
// Notes:   Writes are held and committed at the closing stop
//
// Notes on behaviour
// - First data byte is high half, second low
// - Ack all four write bytes, then standby
// - Ack each of three read instruction bytes
// - Send second byte only after master ack
// - Pointer loads from address, increments per pair read
// - Group command chains writes with repeated starts
// - Held writes apply at closing stop only
// - Master code 00001xxx enters high-speed mode
// - High-speed mode shortens input filtering
// - Stop leaves high-speed mode
// - Repeated start keeps high-speed mode
// - Pointer starts at zero after reset
// - Ack only when address matches strap
// - Direction bit one reads, zero writes
`timescale 1ns/1ps
`default_nettype none
module power_monitor_serial_slave (
  // Clock and reset
  input  wire logic                              clk_in,
  input  wire logic                              resetn_in,
  // Bus pins
  input  wire logic                              scl_in,
  input  wire logic                              sda_in,
  output logic                                   sda_out,
  output logic                                   sda_oe_out,
  // Address strap
  input  wire logic [pmon_i2c_pkg::ADDR_W-1:0]  addr_strap_in,
  // Register file read port
  output logic      [pmon_i2c_pkg::PTR_W-1:0]   rd_addr_out,
  input  wire logic [pmon_i2c_pkg::DATA_W-1:0]  rd_data_in,
  // Register file write port
  output logic                                   wr_strobe_out,
  output logic      [pmon_i2c_pkg::PTR_W-1:0]   wr_addr_out,
  output logic      [pmon_i2c_pkg::DATA_W-1:0]  wr_data_out,
  // Mode
  output logic                                   hs_mode_out
);
  import pmon_i2c_pkg::*;

  logic                 rst_meta_r;
  logic                 rst_n_r;
  logic [ADDR_W+1:0]    sync_q;
  logic [1:0]           filt_w;
  logic [FCNT_W-1:0]    flim;
  logic                 scl;
  logic                 sda;
  logic                 scl_d_r;
  logic                 sda_d_r;
  logic                 scl_rise, scl_fall, start_det, stop_det;
  slave_state_e         state_r;
  slave_state_e         nxt_r;
  logic [3:0]           bit_cnt_r;
  logic [7:0]           shift_r;
  logic                 in_ack_r;
  logic                 mack_r;
  logic [DATA_W-1:0]    tx_sh_r;
  logic                 sda_oe_r;
  logic                 sda_out_r;
  logic [ADDR_W-1:0]    own_addr_r;
  logic                 hs_r;
  logic [PTR_W-1:0]     ptr_r;
  logic [7:0]           hi_r;
  logic                 pend_r;
  logic [PTR_W-1:0]     pend_addr_r;
  logic [DATA_W-1:0]    pend_data_r;
  logic                 wr_strobe_r;
  logic [PTR_W-1:0]     wr_addr_r;
  logic [DATA_W-1:0]    wr_data_r;
  logic                 rx_st, tx_st, byte_done, ack_end, tx_end, is_mc, addr_hit;

  // Reset release through two flops
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  line_sync #(
    .WIDTH (ADDR_W + 2)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_r),
    .d_in     ({addr_strap_in, scl_in, sda_in}),
    .q_out    (sync_q)
  );

  // Spike filter; high-speed mode narrows the window
  assign flim = hs_r ? FCNT_W'(FILT_HS_CYC) : FCNT_W'(FILT_STD_CYC);

  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic              f_r;
    logic [FCNT_W-1:0] c_r;
    always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
        f_r <= 1'b1;
        c_r <= '0;
      end else if (sync_q[g] == f_r) begin
        c_r <= '0;
      end else if (c_r >= flim - 1'b1) begin
        f_r <= sync_q[g];
        c_r <= '0;
      end else begin
        c_r <= c_r + 1'b1;
      end
    end
    assign filt_w[g] = f_r;
  end

  assign scl = filt_w[1];
  assign sda = filt_w[0];

  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  assign scl_rise  = scl & ~scl_d_r;
  assign scl_fall  = ~scl & scl_d_r;
  assign start_det = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_det  = scl & scl_d_r & ~sda_d_r & sda;

  assign rx_st     = (state_r == st_dev) || (state_r == st_reg) ||
                     (state_r == st_dhi) || (state_r == st_dlo);
  assign tx_st     = (state_r == st_thi) || (state_r == st_tlo);
  assign byte_done = scl_fall && rx_st && !in_ack_r && (bit_cnt_r == BYTE_BITS);
  assign ack_end   = scl_fall && in_ack_r;
  assign tx_end    = scl_fall && tx_st && (bit_cnt_r == ACK_SLOT);
  assign is_mc     = (shift_r[7:3] == MC_PREFIX);
  assign addr_hit  = (shift_r[7:1] == own_addr_r);

  // Strap is static; caught only between transfers
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      own_addr_r <= '0;
    end else if (state_r == st_idle) begin
      own_addr_r <= sync_q[ADDR_W+1:2];
    end
  end

  // Protocol sequencer
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r   <= st_idle;
      nxt_r     <= st_idle;
      bit_cnt_r <= '0;
      shift_r   <= '0;
      in_ack_r  <= 1'b0;
      mack_r    <= 1'b0;
      tx_sh_r   <= '0;
      sda_oe_r  <= 1'b0;
    end else if (start_det) begin
      // Plain and repeated starts both open a new id byte
      state_r   <= st_dev;
      bit_cnt_r <= '0;
      in_ack_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
    end else if (stop_det) begin
      state_r   <= st_idle;
      bit_cnt_r <= '0;
      in_ack_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
    end else if (byte_done) begin
      case (state_r)
        st_dev: begin
          if (is_mc) begin
            state_r <= st_wait;
          end else if (addr_hit) begin
            sda_oe_r <= 1'b1;
            in_ack_r <= 1'b1;
            nxt_r    <= (shift_r[0] == DIR_READ) ? st_thi : st_reg;
          end else begin
            state_r <= st_wait;
          end
        end
        st_reg, st_dhi, st_dlo: begin
          sda_oe_r <= 1'b1;
          in_ack_r <= 1'b1;
          nxt_r    <= (state_r == st_reg) ? st_dhi :
                      (state_r == st_dhi) ? st_dlo : st_wait;
        end
        default: begin
          state_r <= st_wait;
        end
      endcase
    end else if (ack_end) begin
      in_ack_r  <= 1'b0;
      state_r   <= nxt_r;
      bit_cnt_r <= '0;
      sda_oe_r  <= 1'b0;
      if (nxt_r == st_thi) begin
        // Word is taken once so both bytes come from one register value
        tx_sh_r   <= {rd_data_in[DATA_W-2:0], 1'b0};
        sda_oe_r  <= ~rd_data_in[DATA_W-1];
        bit_cnt_r <= 4'h1;
      end
    end else if (tx_end) begin
      if (state_r == st_thi && mack_r) begin
        state_r   <= st_tlo;
        sda_oe_r  <= ~tx_sh_r[DATA_W-1];
        tx_sh_r   <= {tx_sh_r[DATA_W-2:0], 1'b0};
        bit_cnt_r <= 4'h1;
      end else begin
        state_r  <= st_wait;
        sda_oe_r <= 1'b0;
      end
    end else if (scl_fall && tx_st) begin
      if (bit_cnt_r == BYTE_BITS) begin
        sda_oe_r  <= 1'b0;
        bit_cnt_r <= ACK_SLOT;
      end else begin
        sda_oe_r  <= ~tx_sh_r[DATA_W-1];
        tx_sh_r   <= {tx_sh_r[DATA_W-2:0], 1'b0};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end else if (scl_rise) begin
      if (rx_st && !in_ack_r && bit_cnt_r < BYTE_BITS) begin
        shift_r   <= {shift_r[6:0], sda};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (tx_st && bit_cnt_r == ACK_SLOT) begin
        mack_r <= ~sda;
      end
    end
  end

  // High-speed mode flag
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hs_r <= 1'b0;
    end else if (stop_det) begin
      hs_r <= 1'b0;
    end else if (byte_done && state_r == st_dev && is_mc) begin
      hs_r <= 1'b1;
    end
  end

  // Register pointer
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ptr_r <= PTR_RESET;
    end else if (byte_done && state_r == st_reg) begin
      ptr_r <= shift_r;
    end else if (tx_end && state_r == st_tlo) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // Held write; only the last one before the stop survives
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hi_r        <= '0;
      pend_r      <= 1'b0;
      pend_addr_r <= '0;
      pend_data_r <= '0;
      wr_strobe_r <= 1'b0;
      wr_addr_r   <= '0;
      wr_data_r   <= '0;
      sda_out_r   <= 1'b0;
    end else begin
      sda_out_r   <= 1'b0;
      wr_strobe_r <= 1'b0;
      if (byte_done && state_r == st_dhi) begin
        hi_r <= shift_r;
      end
      if (byte_done && state_r == st_dlo) begin
        pend_r      <= 1'b1;
        pend_addr_r <= ptr_r;
        pend_data_r <= {hi_r, shift_r};
      end
      if (stop_det) begin
        pend_r      <= 1'b0;
        wr_strobe_r <= pend_r;
        wr_addr_r   <= pend_addr_r;
        wr_data_r   <= pend_data_r;
      end
    end
  end

  assign sda_out       = sda_out_r;
  assign sda_oe_out    = sda_oe_r;
  assign rd_addr_out   = ptr_r;
  assign wr_strobe_out = wr_strobe_r;
  assign wr_addr_out   = wr_addr_r;
  assign wr_data_out   = wr_data_r;
  assign hs_mode_out   = hs_r;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_r);
  sequence s_dev_byte;
    byte_done && state_r == st_dev;
  endsequence
  sequence s_lo_byte;
    byte_done && state_r == st_dlo;
  endsequence
  property p_addr_match;
    s_dev_byte ##0 !addr_hit |=> !sda_oe_r && state_r == st_wait;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("ack without match");
  property p_mc_hs;
    s_dev_byte ##0 is_mc |=> hs_r;
  endproperty
  a_mc_hs: assert property (p_mc_hs) else $error("master code missed");
  property p_mc_nack;
    s_dev_byte ##0 is_mc |=> !sda_oe_r [*2];
  endproperty
  a_mc_nack: assert property (p_mc_nack) else $error("master code acked");
  property p_rd_ack;
    s_dev_byte ##0 (addr_hit && !is_mc) |=> sda_oe_r && in_ack_r;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("id byte not acked");
  property p_hs_stop;
    stop_det |=> !hs_r && flim == FCNT_W'(FILT_STD_CYC);
  endproperty
  a_hs_stop: assert property (p_hs_stop) else $error("hs kept after stop");
  property p_hs_rs;
    start_det && hs_r |=> hs_r && state_r == st_dev;
  endproperty
  a_hs_rs: assert property (p_hs_rs) else $error("hs lost on restart");
  property p_wr_ack;
    s_lo_byte |=> sda_oe_r && nxt_r == st_wait;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("bad write end");
  property p_pair;
    s_lo_byte |=> pend_data_r == {$past(hi_r), $past(shift_r)} && pend_r;
  endproperty
  a_pair: assert property (p_pair) else $error("write halves wrong");
  property p_commit;
    wr_strobe_r |-> $past(stop_det) && $past(pend_r);
  endproperty
  a_commit: assert property (p_commit) else $error("write before stop");
  property p_ptr_load;
    byte_done && state_r == st_reg |=> ptr_r == $past(shift_r);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
  property p_no_mack;
    tx_end && state_r == st_thi && !mack_r |=> state_r == st_wait && !sda_oe_r;
  endproperty
  a_no_mack: assert property (p_no_mack) else $error("sent after nack");

endmodule // power_monitor_serial_slave
`default_nettype wire

// file: src/pmon_i2c_pkg.sv
// Purpose: Shared constants and types for the power monitor serial slave
// Assumes: Core clock of 200 MHz
// Notes:   Filter windows are given in ns and turned into core cycles here
package pmon_i2c_pkg;
  localparam int           CLK_MHZ      = 200;
  localparam int           ADDR_W       = 7;
  localparam int           PTR_W        = 8;
  localparam int           DATA_W       = 16;
  localparam int           FCNT_W       = 4;
  // Glitch windows of the line filters, standard and high-speed
  localparam int           FILT_STD_NS  = 20;
  localparam int           FILT_HS_NS   = 5;
  localparam int           FILT_STD_CYC = (FILT_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int           FILT_HS_CYC  = (FILT_HS_NS * CLK_MHZ + 999) / 1000;
  // Byte framing
  localparam logic [3:0]   BYTE_BITS    = 4'h8;
  localparam logic [3:0]   ACK_SLOT     = 4'h9;
  localparam logic [4:0]   MC_PREFIX    = 5'h01;
  localparam logic         DIR_READ     = 1'b1;
  localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;

  typedef enum logic [2:0] {
    st_idle, st_dev, st_reg, st_dhi, st_dlo, st_thi, st_tlo, st_wait
  } slave_state_e;
endpackage

// file: src/line_sync.sv
// Purpose: Two-flop synchroniser for pins sampled by the core clock
// Assumes: Inputs are quasi-static or slower than the core clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module line_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule // line_sync
`default_nettype wire

// file: sim/pmon_bus_master.sv
// Purpose: Behavioural two-wire bus master driving the power monitor slave
// Assumes: Open-drain wire resolved by the bench; 1 on sda_out means released
// Notes:   SCL stands high between frames; q sets quarter bit time in core cycles
`timescale 1ns/1ps
`default_nettype none
module pmon_bus_master (
  // Clock
  input  wire logic clk_in,
  // Bus pins
  output logic      scl_out,
  output logic      sda_out,
  input  wire logic sda_in
);
  int q = 4;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // All pin changes land on the falling edge, away from the slave's sampling edge
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Sample mid-high so the slave's late data change is settled
  task automatic bit_xfer(input logic v, output logic s);
    wt(q);
    sda_out = v;
    wt(q);
    scl_out = 1'b1;
    wt(q);
    s = sda_in;
    wt(q);
    scl_out = 1'b0;
  endtask
  // Used for the first start and for every repeated start
  task automatic start();
    wt(q);
    sda_out = 1'b1;
    wt(q);
    scl_out = 1'b1;
    wt(q);
    sda_out = 1'b0;
    wt(q);
    scl_out = 1'b0;
  endtask
  // Trailing idle gives the slave time to commit and leave high-speed mode
  task automatic stop();
    wt(q);
    sda_out = 1'b0;
    wt(q);
    scl_out = 1'b1;
    wt(q);
    sda_out = 1'b1;
    wt(4 * q);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask
  // Caller withholds ack on the last byte of a read; reads only from one device
  task automatic rd_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      b[i] = s;
    end
    bit_xfer(~give_ack, s);
  endtask
endmodule // pmon_bus_master
`default_nettype wire

// file: sim/power_monitor_serial_slave_test.sv
// Purpose: Self-checking bench for the power monitor serial slave
// Assumes: Register file modelled here; bus pulled up, open drain
// Notes:   Writes are expected only at the closing stop, via a queue
`timescale 1ns/1ps
`default_nettype none
module power_monitor_serial_slave_test;
  logic        clk_in = 1'b0;
  logic        resetn_in;
  logic        scl, m_sda, dev_sda, sda_oe, hs, wr_strobe, ack;
  logic [6:0]  strap = 7'h40;
  logic [7:0]  rd_addr, wr_addr, b;
  logic [15:0] wr_data;
  logic [15:0] mem [256];
  logic [23:0] exp_q [$];
  int          num_errors = 0;
  int          n_tests = 0;
  int          n_strobes = 0;
  wire         sda_line = m_sda & ~sda_oe;
  always #2.5 clk_in = ~clk_in;
  pmon_bus_master mst (.clk_in(clk_in), .scl_out(scl), .sda_out(m_sda), .sda_in(sda_line));
  power_monitor_serial_slave uut (
    .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(dev_sda), .sda_oe_out(sda_oe), .addr_strap_in(strap),
    .rd_addr_out(rd_addr), .rd_data_in(mem[rd_addr]), .wr_strobe_out(wr_strobe),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data), .hs_mode_out(hs));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Each commit pops the oldest noted write
  always @(posedge clk_in) begin
    if (resetn_in && wr_strobe === 1'b1) begin
      n_strobes++;
      if (exp_q.size() == 0) chk("unexpected_strobe", 16'h0, 16'h1);
      else begin
        chk("wr_addr", {8'h00, exp_q[0][23:16]}, {8'h00, wr_addr});
        chk("wr_data", exp_q[0][15:0], wr_data);
        mem[exp_q[0][23:16]] = exp_q[0][15:0];
        void'(exp_q.pop_front());
      end
    end
  end
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] r, input logic [15:0] d,
                        input logic ea);
    mst.wr_byte({a, 1'b0}, ack);
    chk("ack_id", {15'h0, ea}, {15'h0, ack});
    mst.wr_byte(r, ack);
    chk("ack_reg", {15'h0, ea}, {15'h0, ack});
    mst.wr_byte(d[15:8], ack);
    chk("ack_hi", {15'h0, ea}, {15'h0, ack});
    mst.wr_byte(d[7:0], ack);
    chk("ack_lo", {15'h0, ea}, {15'h0, ack});
  endtask
  // ra selects a random read, else current address; af is the master ack on byte one
  task automatic rd(input logic ra, input logic [7:0] r, input logic af);
    logic [7:0]  p;
    logic [15:0] e;
    p = ra ? r : rd_addr;
    e = mem[p];
    mst.start();
    if (ra) begin
      mst.wr_byte({strap, 1'b0}, ack);
      chk("ack_rid_w", 16'h1, {15'h0, ack});
      mst.wr_byte(r, ack);
      chk("ack_raddr", 16'h1, {15'h0, ack});
      mst.start();
    end
    mst.wr_byte({strap, 1'b1}, ack);
    chk("ack_rid_r", 16'h1, {15'h0, ack});
    mst.rd_byte(af, b);
    chk("rd_hi", {8'h00, e[15:8]}, {8'h00, b});
    if (af) begin
      mst.rd_byte(1'b0, b);
      chk("rd_lo", {8'h00, e[7:0]}, {8'h00, b});
    end
    mst.stop();
    chk("ptr_after", {8'h00, p + 8'(af)}, {8'h00, rd_addr});
  endtask
  initial begin
    logic [7:0]  r;
    logic [15:0] d;
    int          cnt;
    void'($urandom(32'hf357da18));
    resetn_in = 1'b0;
    strap = 7'h40 | 7'($urandom() % 64);
    for (int i = 0; i < 256; i++) mem[i] = 16'($urandom());
    repeat (12) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (12) @(negedge clk_in);
    chk("ptr_reset", 16'h0, {8'h00, rd_addr});
    chk("hs_reset", 16'h0, {15'h0, hs});
    rd(1'b0, 8'h00, 1'b1);
    $display("test current_read done");
    for (int k = 0; k < 3; k++) begin
      mst.q = (k == 2) ? 8 : 4;
      r = 8'($urandom());
      d = 16'($urandom());
      exp_q.push_back({r, d});
      mst.start();
      wr_reg(strap, r, d, 1'b1);
      mst.stop();
      chk("ptr_wr", {8'h00, r}, {8'h00, rd_addr});
      chk("queue_empty", 16'h0, 16'(exp_q.size()));
      rd(1'b1, r, k != 1);
    end
    mst.q = 4;
    $display("test write_read done");
    cnt = n_strobes;
    r = 8'($urandom());
    d = 16'($urandom());
    exp_q.push_back({r, d});
    mst.start();
    wr_reg(strap ^ 7'h01, 8'h11, 16'h2233, 1'b0);
    mst.start();
    wr_reg(strap, r, d, 1'b1);
    mst.start();
    wr_reg(strap ^ 7'h02, 8'h44, 16'h5566, 1'b0);
    chk("no_early_commit", 16'(cnt), 16'(n_strobes));
    mst.stop();
    chk("group_commit", 16'(cnt + 1), 16'(n_strobes));
    $display("test group done");
    for (int x = 0; x < 8; x++) begin
      mst.start();
      mst.wr_byte({5'h01, 3'(x)}, ack);
      chk("mc_nack", 16'h0, {15'h0, ack});
      chk("hs_on", 16'h1, {15'h0, hs});
      if (x == 7) begin
        r = 8'($urandom());
        exp_q.push_back({r, 16'hbeef});
        // Two-cycle quarter bits outrun the wide filter; only the narrow one keeps up
        mst.q = 2;
        mst.start();
        wr_reg(strap, r, 16'hbeef, 1'b1);
        chk("hs_keep", 16'h1, {15'h0, hs});
        rd(1'b1, r, 1'b1);
        mst.q = 4;
      end
      else mst.stop();
      chk("hs_off", 16'h0, {15'h0, hs});
    end
    chk("sda_out_low", 16'h0, {15'h0, dev_sda});
    $display("test high_speed done");
    conclude();
  end
  initial begin
    #400000;
    num_errors++;
    $display("watchdog expired");
    conclude();
  end
endmodule // power_monitor_serial_slave_test
`default_nettype wire
